// file: rtl/asbp_ctrl.sv
// host-side controller driving an asynchronous 16-bit byte-lane sram
`timescale 1ns/1ps
module asbp_ctrl (
    input wire logic clk,
    input wire logic rst,
    // user request side
    input wire logic req_valid,
    input wire logic req_write,
    input wire logic [asbp_pkg::ADDR_W-1:0] req_addr,
    input wire logic [asbp_pkg::DATA_W-1:0] req_wdata,
    input wire logic [1:0] req_lanes,
    output logic req_ready,
    output logic rsp_valid,
    output logic [asbp_pkg::DATA_W-1:0] rsp_rdata,
    // memory pins
    output logic [asbp_pkg::ADDR_W-1:0] mem_addr,
    output logic chip_select_low_active,
    output logic chip_select_high_active,
    output logic write_strobe_n,
    output logic output_gate_n,
    output logic upper_byte_gate_n,
    output logic lower_byte_gate_n,
    input wire logic [asbp_pkg::DATA_W-1:0] mem_dq_in,
    output logic [asbp_pkg::DATA_W-1:0] mem_dq_out,
    output logic [1:0] mem_dq_oe
);
    import asbp_pkg::*;

    // ------------------------------------------------------------
    // pin input synchroniser
    // ------------------------------------------------------------
    logic [DATA_W-1:0] dq_meta;
    logic [DATA_W-1:0] dq_sync;
    always_ff @(posedge clk) begin
        dq_meta <= mem_dq_in;
        dq_sync <= dq_meta;
    end

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    asbp_state_t state, next_state;
    logic [3:0] cnt, next_cnt;
    logic is_write, next_is_write;
    logic [1:0] lanes, next_lanes;
    logic [DATA_W-1:0] wdata, next_wdata;

    logic next_req_ready, next_rsp_valid;
    logic [DATA_W-1:0] next_rsp_rdata;
    logic [ADDR_W-1:0] next_mem_addr;
    logic next_cs_l, next_cs_h, next_we_n, next_oe_n;
    logic next_ub_n, next_lb_n;
    logic [DATA_W-1:0] next_dq_out;
    logic [1:0] next_dq_oe;

    // lane gates are active low, lane 0 is the lower byte
    function automatic logic [1:0] gates_n(input logic [1:0] l);
        return ~l;
    endfunction : gates_n

    always_comb begin
        next_state = state;
        next_cnt = cnt;
        next_is_write = is_write;
        next_lanes = lanes;
        next_wdata = wdata;
        next_req_ready = 1'b0;
        next_rsp_valid = 1'b0;
        next_rsp_rdata = rsp_rdata;
        next_mem_addr = mem_addr;
        // idle: fully deselected at definite levels
        next_cs_l = 1'b1; // R9
        next_cs_h = 1'b0; // R9
        next_we_n = 1'b1;
        next_oe_n = 1'b1;
        next_ub_n = 1'b1;
        next_lb_n = 1'b1;
        next_dq_out = mem_dq_out;
        next_dq_oe = 2'b00;
        case (state)
            ASBP_IDLE: begin
                next_req_ready = 1'b1;
                if (req_valid && req_ready) begin
                    next_req_ready = 1'b0;
                    next_is_write = req_write;
                    next_lanes = req_lanes;
                    next_wdata = req_wdata;
                    // address placed one cycle ahead of select
                    next_mem_addr = req_addr; // R8
                    next_cnt = 4'(SETUP_CYC - 1);
                    next_state = ASBP_SETUP;
                end
            end
            ASBP_SETUP: begin
                next_cs_l = 1'b0; // R1
                next_cs_h = 1'b1; // R1
                {next_ub_n, next_lb_n} = gates_n(lanes); // R11
                if (is_write) begin
                    // strobe falls with select on the same edge; data driven from the start
                    next_we_n = 1'b0; // R2
                    next_dq_out = wdata;
                    next_dq_oe = lanes; // R11 R12
                    next_cnt = 4'(WRITE_CYC - 1);
                    next_state = ASBP_WRITE;
                end else begin
                    next_oe_n = 1'b0;
                    next_cnt = 4'(READ_CYC - 1);
                    next_state = ASBP_READ;
                end
            end
            ASBP_READ: begin
                // strobe stays high throughout
                next_we_n = 1'b1; // R6
                next_cs_l = 1'b0;
                next_cs_h = 1'b1;
                next_oe_n = 1'b0;
                {next_ub_n, next_lb_n} = gates_n(lanes);
                if (cnt == CNT_ZERO) begin
                    // two cycles of slack cover the synchroniser delay
                    for (int i = 0; i < 2; i++) begin
                        next_rsp_rdata[i*8 +: 8] =
                            lanes[i] ? dq_sync[i*8 +: 8] : 8'h00; // R11
                    end
                    next_rsp_valid = 1'b1;
                    next_cnt = 4'(TURN_CYC - 1);
                    next_state = ASBP_TURN;
                    next_cs_l = 1'b1;
                    next_cs_h = 1'b0;
                    next_oe_n = 1'b1;
                    next_ub_n = 1'b1;
                    next_lb_n = 1'b1;
                end else begin
                    next_cnt = cnt - 4'h1;
                end
            end
            ASBP_WRITE: begin
                next_cs_l = 1'b0;
                next_cs_h = 1'b1;
                {next_ub_n, next_lb_n} = gates_n(lanes);
                next_dq_oe = lanes;
                if (cnt == CNT_ZERO) begin
                    // strobe rises first and ends the write; data held
                    next_we_n = 1'b1; // R3
                    next_cnt = 4'(HOLD_CYC - 1);
                    next_state = ASBP_HOLD;
                end else begin
                    // pulse covers float time plus data setup
                    next_we_n = 1'b0; // R4
                    next_cnt = cnt - 4'h1;
                end
            end
            ASBP_HOLD: begin
                // data still driven one cycle past the terminating edge
                next_dq_oe = 2'b00; // R3
                next_rsp_valid = 1'b1;
                next_state = ASBP_IDLE;
                next_req_ready = 1'b1;
            end
            ASBP_TURN: begin
                // let the device release the bus before any new drive
                if (cnt == CNT_ZERO) begin
                    next_state = ASBP_IDLE;
                    next_req_ready = 1'b1;
                end else begin
                    next_cnt = cnt - 4'h1;
                end
            end
            default: begin
                next_state = ASBP_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state <= ASBP_IDLE;
            cnt <= CNT_ZERO;
            is_write <= 1'b0;
            lanes <= 2'h0;
            wdata <= '0;
            req_ready <= 1'b0;
            rsp_valid <= 1'b0;
            rsp_rdata <= '0;
            mem_addr <= '0;
            chip_select_low_active <= 1'b1;
            chip_select_high_active <= 1'b0;
            write_strobe_n <= 1'b1;
            output_gate_n <= 1'b1;
            upper_byte_gate_n <= LANES_OFF[1];
            lower_byte_gate_n <= LANES_OFF[0];
            mem_dq_out <= '0;
            mem_dq_oe <= 2'b00;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
            is_write <= next_is_write;
            lanes <= next_lanes;
            wdata <= next_wdata;
            req_ready <= next_req_ready;
            rsp_valid <= next_rsp_valid;
            rsp_rdata <= next_rsp_rdata;
            mem_addr <= next_mem_addr;
            chip_select_low_active <= next_cs_l;
            chip_select_high_active <= next_cs_h;
            write_strobe_n <= next_we_n;
            output_gate_n <= next_oe_n;
            upper_byte_gate_n <= next_ub_n;
            lower_byte_gate_n <= next_lb_n;
            mem_dq_out <= next_dq_out;
            mem_dq_oe <= next_dq_oe;
        end
    end
endmodule : asbp_ctrl

// file: rtl/asbp_pkg.sv
// package: constants for the asynchronous sram byte-port host controller
// Operation
// R1: device selected only with low-active select low, high-active select high.
// R2: internal write is the overlap of strobe, select and a byte gate.
// R3: host holds write data stable around the edge that ends the write.
// R4: strobe-only write with output gate low lasts float time plus setup.
// R5: device floats data when deselected, output gate high or lane gate high.
// R6: host keeps write strobe high for the whole of any read.
// R7: selected with gates low, device shows new data per address change.
// R8: host presents a valid address no later than select going active.
// R9: host drives select inputs to definite high or low, never mid-level.
// R10: device powers down when deselected or both byte gates are high.
// R11: lower gate covers bits 0 to 7, upper gate bits 8 to 15.
// R12: during a write device ignores output gate and keeps drivers off.
package asbp_pkg;
    localparam int ADDR_W = 18;
    localparam int DATA_W = 16;
    localparam int CLK_PERIOD_NS = 10;
    // timing figures in ns
    localparam int READ_CYCLE_NS = 45;
    localparam int ADDR_TO_DATA_NS = 45;
    localparam int WRITE_PULSE_NS = 35;
    localparam int write_to_float_time = 18;
    localparam int data_setup_time = 25;
    localparam int DATA_HOLD_NS = 0;
    localparam int OE_TO_FLOAT_NS = 18;
    // least times round up to whole cycles, at least one
    function automatic int ns_min(input int ns);
        int c;
        c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction : ns_min
    localparam int SETUP_CYC = 1;
    // two extra cycles: the pin passes two flops before it is taken
    localparam int READ_CYC = ns_min(ADDR_TO_DATA_NS) + 2;
    localparam int WPULSE_A = ns_min(write_to_float_time + data_setup_time);
    localparam int WPULSE_B = ns_min(WRITE_PULSE_NS);
    localparam int WRITE_CYC = (WPULSE_A > WPULSE_B) ? WPULSE_A : WPULSE_B;
    localparam int HOLD_CYC = ns_min(DATA_HOLD_NS);
    localparam int TURN_CYC = ns_min(OE_TO_FLOAT_NS);
    localparam logic [3:0] CNT_ZERO = 4'h0;
    localparam logic [1:0] LANES_OFF = 2'h3;

    typedef enum logic [2:0] {
        ASBP_IDLE = 3'b000,
        ASBP_SETUP = 3'b001,
        ASBP_READ = 3'b010,
        ASBP_WRITE = 3'b011,
        ASBP_HOLD = 3'b100,
        ASBP_TURN = 3'b101
    } asbp_state_t;
endpackage : asbp_pkg

// file: tb/asbp_ctrl_properties.sv
// checker: pin-level timing rules of the byte-port host controller
`timescale 1ns/1ps
module asbp_checker (
    input wire logic clk,
    input wire logic rst,
    input wire logic [asbp_pkg::ADDR_W-1:0] mem_addr,
    input wire logic chip_select_low_active,
    input wire logic chip_select_high_active,
    input wire logic write_strobe_n,
    input wire logic output_gate_n,
    input wire logic [asbp_pkg::DATA_W-1:0] mem_dq_out,
    input wire logic [1:0] mem_dq_oe
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    property p_sel_pair;
        chip_select_low_active != chip_select_high_active;
    endproperty
    a_sel_pair: assert property (p_sel_pair)
        else $error("select inputs not complementary");
    property p_addr_hold;
        !chip_select_low_active |-> $stable(mem_addr);
    endproperty
    a_addr_hold: assert property (p_addr_hold)
        else $error("address moved while selected");
    property p_read_sel;
        $fell(output_gate_n) |-> $rose(chip_select_high_active);
    endproperty
    a_read_sel: assert property (p_read_sel)
        else $error("read not select-controlled");
    property p_no_we_read;
        !output_gate_n |-> write_strobe_n;
    endproperty
    a_no_we_read: assert property (p_no_we_read)
        else $error("strobe low during read");
    property p_no_fight;
        mem_dq_oe != 2'h0 |-> output_gate_n;
    endproperty
    a_no_fight: assert property (p_no_fight)
        else $error("host drives while output gate low");
    property p_pulse;
        $fell(write_strobe_n) |-> !write_strobe_n [*5] ##1 write_strobe_n;
    endproperty
    a_pulse: assert property (p_pulse)
        else $error("write strobe width wrong");
    property p_data_hold;
        !write_strobe_n |=> $stable(mem_dq_out) && $stable(mem_dq_oe);
    endproperty
    a_data_hold: assert property (p_data_hold)
        else $error("write data moved around strobe end");
    property p_end_order;
        $rose(write_strobe_n) |->
            !chip_select_low_active ##1 chip_select_low_active;
    endproperty
    a_end_order: assert property (p_end_order)
        else $error("write not ended by strobe");
    c_read: cover property ($fell(output_gate_n));
    c_write: cover property ($fell(write_strobe_n));
    c_byte: cover property ($fell(write_strobe_n) && mem_dq_oe == 2'h1);
endmodule : asbp_checker
bind asbp_ctrl asbp_checker u_chk (.clk(clk), .rst(rst), .mem_addr(mem_addr),
    .chip_select_low_active(chip_select_low_active),
    .chip_select_high_active(chip_select_high_active),
    .write_strobe_n(write_strobe_n), .output_gate_n(output_gate_n),
    .mem_dq_out(mem_dq_out), .mem_dq_oe(mem_dq_oe));

// file: tb/asbp_sram_model.sv
// partner model: behavioural byte-lane static memory at the pins
`timescale 1ns/1ps
module asbp_sram_model (
    input wire logic [asbp_pkg::ADDR_W-1:0] addr,
    input wire logic cs_lo,
    input wire logic cs_hi,
    input wire logic we_n,
    input wire logic oe_n,
    input wire logic ub_n,
    input wire logic lb_n,
    input wire logic [asbp_pkg::DATA_W-1:0] dq_pin,
    output logic [asbp_pkg::DATA_W-1:0] dq_drive
);
    import asbp_pkg::*;
    logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
    logic sel;
    logic [1:0] lane;
    assign sel = !cs_lo && cs_hi;
    assign lane = ~{ub_n, lb_n};
    // floating lanes show the inverse so a stale byte never looks valid
    always_comb begin
        for (int i = 0; i < 2; i++)
            dq_drive[i*8+:8] = (sel && we_n && !oe_n && lane[i]) ?
                mem[addr][i*8+:8] : ~mem[addr][i*8+:8];
    end
    always @* begin
        if (sel && !we_n)
            for (int i = 0; i < 2; i++)
                if (lane[i]) mem[addr][i*8+:8] = dq_pin[i*8+:8];
    end
endmodule : asbp_sram_model

// file: tb/asbp_ctrl_tb_top.sv
// testbench: table-driven accesses, then reset in mid-access
`timescale 1ns/1ps
module asbp_ctrl_tb_top;
    import asbp_pkg::*;
    typedef struct {logic w; logic [17:0] a; logic [15:0] d;
        logic [1:0] l; logic [15:0] e;} asbp_row_t;
    logic clk, rst, vld, wr, rdy, rsp, cl, ch, we_n, oe_n, ub_n, lb_n;
    logic [ADDR_W-1:0] addr, maddr;
    logic [DATA_W-1:0] wd, rd, dq_o, dq_i, mq;
    logic [1:0] lanes, oe;
    int err_total = 0;
    int n_tests = 0;
    asbp_row_t rows [8] = '{'{1, 18'h0012, 16'h1234, 2'h3, 0},
        '{1, 18'h3_ffff, 16'h5a5a, 2'h2, 0}, '{0, 18'h0012, 0, 2'h3, 16'h1234},
        '{1, 18'h0012, 16'habcd, 2'h1, 0}, '{0, 18'h0012, 0, 2'h3, 16'h12cd},
        '{0, 18'h3_ffff, 0, 2'h2, 16'h5a00}, '{1, 18'h0012, 16'hffff, 2'h0, 0},
        '{0, 18'h0012, 0, 2'h1, 16'h00cd}};
    assign dq_i[7:0] = oe[0] ? dq_o[7:0] : mq[7:0];
    assign dq_i[15:8] = oe[1] ? dq_o[15:8] : mq[15:8];
    asbp_ctrl dut (.clk(clk), .rst(rst), .req_valid(vld), .req_write(wr),
        .req_addr(addr), .req_wdata(wd), .req_lanes(lanes), .req_ready(rdy),
        .rsp_valid(rsp), .rsp_rdata(rd), .mem_addr(maddr),
        .chip_select_low_active(cl), .chip_select_high_active(ch),
        .write_strobe_n(we_n), .output_gate_n(oe_n), .upper_byte_gate_n(ub_n),
        .lower_byte_gate_n(lb_n), .mem_dq_in(dq_i), .mem_dq_out(dq_o),
        .mem_dq_oe(oe));
    asbp_sram_model u_mem (.addr(maddr), .cs_lo(cl), .cs_hi(ch), .we_n(we_n),
        .oe_n(oe_n), .ub_n(ub_n), .lb_n(lb_n), .dq_pin(dq_i), .dq_drive(mq));
    task automatic chk_data(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("Error %0t: value %h expected %h", $time, got, exp);
        end
    endtask : chk_data
    task automatic xfer(input asbp_row_t r);
        int n;
        n = 0;
        while (rdy !== 1'b1 && n < 40) begin
            @(posedge clk);
            #1;
            n++;
        end
        {vld, wr, addr, wd, lanes} = {1'b1, r.w, r.a, r.d, r.l};
        @(posedge clk);
        #1;
        vld = 1'b0;
        n = 0;
        while (rsp !== 1'b1 && n < 40) begin
            @(posedge clk);
            #1;
            n++;
        end
        chk_data(16'(n), r.w ? 16'h0007 : 16'h0008);
        if (!r.w) chk_data(rd, r.e);
    endtask : xfer
    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : stop_test
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        #20000;
        err_total++;
        $display("Error %0t: watchdog expired", $time);
        stop_test();
    end
    initial begin
        {rst, vld, wr, addr, wd, lanes} = {1'b1, 38'h0};
        repeat (16) @(posedge clk);
        #1;
        rst = 1'b0;
        for (int i = 0; i < 8; i++) begin
            xfer(rows[i]);
            $display("row %0d done", i);
        end
        {vld, wr, addr, lanes} = {1'b1, 1'b0, 18'h0012, 2'h3};
        repeat (4) @(posedge clk);
        #1;
        vld = 1'b0;
        rst = 1'b1;
        @(posedge clk);
        #1;
        rst = 1'b0;
        chk_data({7'h00, cl, ch, we_n, oe_n, ub_n, lb_n, oe, rdy},
            16'h0178);
        @(posedge clk);
        #1;
        chk_data({15'h0000, rdy}, 16'h0001);
        xfer(rows[4]);
        $display("reset test done");
        stop_test();
    end
endmodule : asbp_ctrl_tb_top
